// file: zsc_pkg.sv
package zsc_pkg;

  localparam int DW  = 32;
  localparam int AW  = 8;
  localparam int OPW = 128;
  localparam int CW  = 8;

  localparam logic [AW-1:0] ADDR_CTRL       = 8'h00;
  localparam logic [AW-1:0] ADDR_ZERO_POINT = 8'h04;
  localparam logic [AW-1:0] ADDR_SPAN_POINT = 8'h08;
  localparam logic [AW-1:0] ADDR_SPAN_GAIN  = 8'h0C;
  localparam logic [AW-1:0] ADDR_ZERO_ADJ   = 8'h10;
  localparam logic [AW-1:0] ADDR_ZERO_POS   = 8'h14;
  localparam logic [AW-1:0] ADDR_SPAN_POS   = 8'h18;
  localparam logic [AW-1:0] ADDR_INPUT      = 8'h1C;
  localparam logic [AW-1:0] ADDR_RESULT     = 8'h20;
  localparam logic [AW-1:0] ADDR_STATUS     = 8'h24;

  localparam int CTRL_ANYPOINT_BIT  = 0;
  localparam int CTRL_UNIVERSAL_BIT = 1;
  localparam int STAT_BUSY_BIT      = 0;
  localparam int STAT_DONE_BIT      = 1;
  localparam int STAT_DIVZERO_BIT   = 2;

  // gain and position scales: 0.0001, 0.0000001 and 0.0001
  localparam logic [DW-1:0] GAIN_SCALE_STD  = 32'h0000_2710;
  localparam logic [DW-1:0] GAIN_SCALE_UNIV = 32'h0098_9680;
  localparam logic [DW-1:0] POS_SCALE       = 32'h0000_2710;

  localparam logic [DW-1:0] GAIN_RESET      = 32'h0000_2710;
  localparam logic [15:0]   SPAN_RESET      = 16'h0FA0;
  localparam logic [15:0]   ZPOS_RESET      = 16'h01F4;
  localparam logic [15:0]   SPOS_RESET      = 16'h251C;

  localparam logic [CW-1:0] DIV_STEPS       = 8'h80;

  typedef struct packed {
    logic               anypoint;
    logic               universal;
    logic signed [15:0] zero_point;
    logic signed [15:0] span_point;
    logic        [31:0] span_gain;
    logic signed [15:0] zero_adj;
    logic        [15:0] zero_pos;
    logic        [15:0] span_pos;
    logic signed [15:0] x;
  } zsc_param_type;

  typedef struct packed {
    logic signed [OPW-1:0] num;
    logic signed [OPW-1:0] den;
  } zsc_frac_type;

endpackage

// file: zsc_operand.sv
`timescale 1ns/10ps
module zsc_operand
  import zsc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire zsc_param_type prm,
  output zsc_frac_type       frac
);

  logic signed [OPW-1:0] a;
  logic signed [OPW-1:0] s;
  logic signed [OPW-1:0] d;
  logic signed [OPW-1:0] x;
  logic signed [OPW-1:0] e;
  logic signed [OPW-1:0] g;
  logic signed [OPW-1:0] p;
  logic signed [OPW-1:0] bs;
  logic signed [OPW-1:0] cs;
  logic signed [OPW-1:0] ap;
  logic signed [OPW-1:0] den_any;

  // every product is carried scaled, so the one final division does all rounding
  always_comb
  begin
    a  = OPW'(prm.zero_point);
    s  = OPW'(prm.span_point);
    d  = OPW'(prm.zero_adj);
    x  = OPW'(prm.x);
    e  = OPW'(prm.span_gain);
    g  = prm.universal ? OPW'(GAIN_SCALE_UNIV) : OPW'(GAIN_SCALE_STD);
    p  = OPW'(POS_SCALE);
    ap = a * p;
    bs = (s - a) * OPW'(prm.zero_pos) + ap;
    cs = (s - a) * OPW'(prm.span_pos) + ap;
    den_any = (cs - bs) * g;
    if (prm.anypoint)
    begin
      frac.num = (x * p - bs) * ((cs - ap) * e - (bs - ap) * g)
                 + (d * p + bs) * den_any;
      frac.den = den_any * p;
    end
    else
    begin
      frac.num = (x - a) * e + (a + d) * g;
      frac.den = g;
    end
  end

  a_gain_scale_std: assert property (@(posedge clk) disable iff (rst)
    (!prm.anypoint && !prm.universal) |-> frac.den == 128'd10000)
    else $error("standard gain scale is not 10000");

  a_gain_scale_univ: assert property (@(posedge clk) disable iff (rst)
    (!prm.anypoint && prm.universal) |-> frac.den == 128'd10000000)
    else $error("universal gain scale is not 10000000");

endmodule

// file: zsc_divider.sv
`timescale 1ns/10ps
module zsc_divider
  import zsc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               start,
  input  wire zsc_frac_type       frac,
  output logic                    done,
  output logic                    div_zero,
  output logic signed [DW-1:0]    quot
);

  typedef enum logic [1:0] {D_IDLE, D_RUN, D_ROUND} zsc_dstate_type;

  zsc_dstate_type     state;
  zsc_dstate_type     next_state;
  logic [OPW-1:0]     dvd;
  logic [OPW-1:0]     next_dvd;
  logic [OPW-1:0]     dsr;
  logic [OPW-1:0]     next_dsr;
  logic [OPW-1:0]     rem;
  logic [OPW-1:0]     next_rem;
  logic [CW-1:0]      cnt;
  logic [CW-1:0]      next_cnt;
  logic               neg;
  logic               next_neg;
  logic               next_done;
  logic               next_div_zero;
  logic signed [DW-1:0] next_quot;
  logic [OPW-1:0]     rem_sh;
  logic [OPW-1:0]     q_rnd;

  always_comb
  begin
    next_state    = state;
    next_dvd      = dvd;
    next_dsr      = dsr;
    next_rem      = rem;
    next_cnt      = cnt;
    next_neg      = neg;
    next_done     = 1'b0;
    next_div_zero = div_zero;
    next_quot     = quot;
    rem_sh        = {rem[OPW-2:0], dvd[OPW-1]};
    q_rnd         = '0;
    case (state)
      D_IDLE:
        if (start)
        begin
          next_dvd = frac.num[OPW-1] ? OPW'(-frac.num) : frac.num;
          next_dsr = frac.den[OPW-1] ? OPW'(-frac.den) : frac.den;
          next_neg = frac.num[OPW-1] ^ frac.den[OPW-1];
          next_rem = '0;
          next_cnt = '0;
          next_state = D_RUN;
        end
      D_RUN:
      begin
        next_dvd = {dvd[OPW-2:0], 1'b0};
        if (rem_sh >= dsr)
        begin
          next_rem = rem_sh - dsr;
          next_dvd[0] = 1'b1;
        end
        else
          next_rem = rem_sh;
        next_cnt = cnt + 8'h01;
        if (next_cnt == DIV_STEPS)
          next_state = D_ROUND;
      end
      D_ROUND:
      begin
        // half away from zero; the remainder is compared against half the divisor
        q_rnd = ({rem, 1'b0} >= {1'b0, dsr}) ? dvd + 128'd1 : dvd;
        next_div_zero = (dsr == '0);
        next_quot = (dsr == '0) ? '0 : (neg ? DW'(-q_rnd) : DW'(q_rnd));
        next_done = 1'b1;
        next_state = D_IDLE;
      end
      default:
        next_state = D_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state    <= D_IDLE;
      dvd      <= '0;
      dsr      <= '0;
      rem      <= '0;
      cnt      <= '0;
      neg      <= 1'b0;
      done     <= 1'b0;
      div_zero <= 1'b0;
      quot     <= '0;
    end
    else
    begin
      state    <= next_state;
      dvd      <= next_dvd;
      dsr      <= next_dsr;
      rem      <= next_rem;
      cnt      <= next_cnt;
      neg      <= next_neg;
      done     <= next_done;
      div_zero <= next_div_zero;
      quot     <= next_quot;
    end
  end

  sequence s_div_start;
    state == D_IDLE && start;
  endsequence

  a_div_latency: assert property (@(posedge clk) disable iff (rst)
    s_div_start |-> ##130 done)
    else $error("division did not finish in 130 cycles");

  a_round_half: assert property (@(posedge clk) disable iff (rst)
    (state == D_ROUND && dsr != '0) |-> (rem < dsr) ##1
      (done && !div_zero && quot == $past(neg ? DW'(-q_rnd) : DW'(q_rnd))))
    else $error("rounded quotient out of half step");

endmodule

// file: zsc_correction.sv
`timescale 1ns/10ps
// Contract
// - simple mode: (input - range min) times gain, plus range min plus zero adjust.
// - stored span gain is an integer in units of 0.0001.
// - any-point mode: (X-B)*((C-A)*E-B+A)/(C-B)+D+B.
// - each position is (span point - zero point) times its fraction plus zero point.
// - zero and span position settings are fractions scaled by 0.0001.
// - universal-input variant scales the span gain by 0.0000001.
module zsc_correction
  import zsc_pkg::*;
(
  input  wire logic          CORE_CLK,
  input  wire logic          SYS_RST,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [AW-1:0] PADDR,
  input  wire logic [DW-1:0] PWDATA,
  output logic      [DW-1:0] PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  output logic      [DW-1:0] PV_OUT,
  output logic               PV_VALID
);

  typedef enum logic {S_IDLE, S_BUSY} zsc_state_type;

  zsc_param_type      prm;
  zsc_param_type      next_prm;
  zsc_frac_type       frac;
  zsc_state_type      state;
  zsc_state_type      next_state;
  logic               start;
  logic               next_start;
  logic               done_flag;
  logic               next_done_flag;
  logic               div_done;
  logic               div_zero;
  logic signed [DW-1:0] quot;
  logic [DW-1:0]      result;
  logic [DW-1:0]      next_result;
  logic [DW-1:0]      next_prdata;
  logic               next_pready;
  logic               next_pslverr;
  logic [DW-1:0]      next_pv_out;
  logic               next_pv_valid;
  logic               access;
  logic               wr_fire;
  logic               mapped;
  logic [DW-1:0]      rd_mux;

  zsc_operand u_operand
  (
    .clk  (CORE_CLK),
    .rst  (SYS_RST),
    .prm  (prm),
    .frac (frac)
  );

  zsc_divider u_divider
  (
    .clk      (CORE_CLK),
    .rst      (SYS_RST),
    .start    (start),
    .frac     (frac),
    .done     (div_done),
    .div_zero (div_zero),
    .quot     (quot)
  );

  // one wait state: pready rises in the second access cycle, from a flop
  assign access  = PSEL && PENABLE && !PREADY;
  assign wr_fire = PSEL && PENABLE && PREADY && PWRITE;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = '0;
    case (PADDR)
      ADDR_CTRL:
      begin
        rd_mux[CTRL_ANYPOINT_BIT]  = prm.anypoint;
        rd_mux[CTRL_UNIVERSAL_BIT] = prm.universal;
      end
      ADDR_ZERO_POINT: rd_mux = DW'(prm.zero_point);
      ADDR_SPAN_POINT: rd_mux = DW'(prm.span_point);
      ADDR_SPAN_GAIN:  rd_mux = prm.span_gain;
      ADDR_ZERO_ADJ:   rd_mux = DW'(prm.zero_adj);
      ADDR_ZERO_POS:   rd_mux = DW'(prm.zero_pos);
      ADDR_SPAN_POS:   rd_mux = DW'(prm.span_pos);
      ADDR_INPUT:      rd_mux = DW'(prm.x);
      ADDR_RESULT:     rd_mux = result;
      ADDR_STATUS:
      begin
        rd_mux[STAT_BUSY_BIT]    = (state == S_BUSY);
        rd_mux[STAT_DONE_BIT]    = done_flag;
        rd_mux[STAT_DIVZERO_BIT] = div_zero;
      end
      default: mapped = 1'b0;
    endcase
  end

  // bus answer
  always_comb
  begin
    next_pready  = access;
    next_prdata  = PRDATA;
    next_pslverr = 1'b0;
    if (access)
    begin
      next_prdata  = PWRITE ? '0 : rd_mux;
      // parameters are frozen while a conversion runs, so such writes are refused
      next_pslverr = !mapped || (PWRITE && (state == S_BUSY) && PADDR != ADDR_STATUS)
                     || (PWRITE && (PADDR == ADDR_RESULT || PADDR == ADDR_STATUS));
    end
  end

  // parameter store and conversion control
  always_comb
  begin
    next_prm       = prm;
    next_state     = state;
    next_start     = 1'b0;
    next_done_flag = done_flag;
    next_result    = result;
    next_pv_out    = PV_OUT;
    next_pv_valid  = 1'b0;
    if (wr_fire && !PSLVERR)
    begin
      case (PADDR)
        ADDR_CTRL:
        begin
          next_prm.anypoint  = PWDATA[CTRL_ANYPOINT_BIT];
          next_prm.universal = PWDATA[CTRL_UNIVERSAL_BIT];
        end
        ADDR_ZERO_POINT: next_prm.zero_point = PWDATA[15:0];
        ADDR_SPAN_POINT: next_prm.span_point = PWDATA[15:0];
        ADDR_SPAN_GAIN:  next_prm.span_gain  = PWDATA;
        ADDR_ZERO_ADJ:   next_prm.zero_adj   = PWDATA[15:0];
        ADDR_ZERO_POS:   next_prm.zero_pos   = PWDATA[15:0];
        ADDR_SPAN_POS:   next_prm.span_pos   = PWDATA[15:0];
        ADDR_INPUT:
        begin
          next_prm.x     = PWDATA[15:0];
          next_start     = 1'b1;
          next_done_flag = 1'b0;
          next_state     = S_BUSY;
        end
        default: next_prm = prm;
      endcase
    end
    if (state == S_BUSY && div_done)
    begin
      next_result    = quot;
      next_pv_out    = quot;
      next_pv_valid  = 1'b1;
      next_done_flag = 1'b1;
      next_state     = S_IDLE;
    end
    if (state != S_IDLE && state != S_BUSY)
      next_state = S_IDLE;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      prm.anypoint   <= 1'b0;
      prm.universal  <= 1'b0;
      prm.zero_point <= '0;
      prm.span_point <= SPAN_RESET;
      prm.span_gain  <= GAIN_RESET;
      prm.zero_adj   <= '0;
      prm.zero_pos   <= ZPOS_RESET;
      prm.span_pos   <= SPOS_RESET;
      prm.x          <= '0;
      state          <= S_IDLE;
      start          <= 1'b0;
      done_flag      <= 1'b0;
      result         <= '0;
      PRDATA         <= '0;
      PREADY         <= 1'b0;
      PSLVERR        <= 1'b0;
      PV_OUT         <= '0;
      PV_VALID       <= 1'b0;
    end
    else
    begin
      prm            <= next_prm;
      state          <= next_state;
      start          <= next_start;
      done_flag      <= next_done_flag;
      result         <= next_result;
      PRDATA         <= next_prdata;
      PREADY         <= next_pready;
      PSLVERR        <= next_pslverr;
      PV_OUT         <= next_pv_out;
      PV_VALID       <= next_pv_valid;
    end
  end

  // checks
  sequence s_convert_req;
    wr_fire && !PSLVERR && PADDR == ADDR_INPUT;
  endsequence

  sequence s_convert_end;
    PV_VALID && PV_OUT == result;
  endsequence

  a_conv_complete: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    s_convert_req |-> ##132 s_convert_end)
    else $error("adjusted value not delivered 132 cycles after input write");

  a_simple_form: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (!prm.anypoint && state == S_IDLE) |->
      frac.num == ((OPW'(prm.x) - OPW'(prm.zero_point)) * OPW'(prm.span_gain)
                  + (OPW'(prm.zero_point) + OPW'(prm.zero_adj)) * OPW'(frac.den)))
    else $error("simple mode numerator wrong");

  a_anypoint_den: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (prm.anypoint && !prm.universal) |->
      frac.den == (OPW'(prm.span_point) - OPW'(prm.zero_point))
                  * (OPW'(prm.span_pos) - OPW'(prm.zero_pos)) * 128'd100000000)
    else $error("any-point denominator wrong");

  a_unit_scale: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (!prm.anypoint && prm.x == prm.zero_point && prm.zero_adj == '0 && state == S_IDLE)
      |-> frac.num == OPW'(prm.zero_point) * frac.den)
    else $error("zero input does not map to range minimum");

  a_anypoint_zero: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (prm.anypoint && !prm.universal && prm.zero_point == '0 && prm.zero_adj == '0
      && OPW'(prm.x) * 128'd10000 == OPW'(prm.span_point) * OPW'(prm.zero_pos))
      |-> frac.num == OPW'(prm.x) * frac.den)
    else $error("input at zero position does not map to itself");

  a_pv_stable: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !PV_VALID |=> (PV_OUT == $past(PV_OUT)) || PV_VALID)
    else $error("process value changed without a valid pulse");

  a_bus_wait: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (PSEL && !PENABLE) ##1 (PSEL && PENABLE) |-> !PREADY ##1 PREADY)
    else $error("access phase not answered after one wait state");

  // error and read data only ride on the one-cycle ready pulse
  a_ready_pulse: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    PREADY |=> !PREADY)
    else $error("ready stood longer than one cycle");

  a_err_with_ready: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    PSLVERR |-> PREADY)
    else $error("error flag without ready");

  a_write_rdata_zero: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (PREADY && PWRITE) |-> PRDATA == '0)
    else $error("read data not zero on a write");

  a_rdata_hold: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !PREADY |=> PREADY || $stable(PRDATA))
    else $error("read data changed outside an answer");

  a_unmapped_err: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (access && PADDR > ADDR_STATUS) |=> PSLVERR)
    else $error("unmapped address not refused");

  a_busy_write_err: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (access && PWRITE && state == S_BUSY && PADDR != ADDR_STATUS) |=> PSLVERR)
    else $error("write during conversion not refused");

  a_ctrl_write: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (wr_fire && !PSLVERR && PADDR == ADDR_CTRL) |=> prm.anypoint == $past(PWDATA[0])
      && prm.universal == $past(PWDATA[1]))
    else $error("mode bits not taken from write");

  a_gain_write: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (wr_fire && !PSLVERR && PADDR == ADDR_SPAN_GAIN) |=> prm.span_gain == $past(PWDATA))
    else $error("span gain not taken from write");

  a_pos_write: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (wr_fire && !PSLVERR && PADDR == ADDR_ZERO_POS) |=> prm.zero_pos == $past(PWDATA[15:0]))
    else $error("zero position not taken from write");

  a_start_busy: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    s_convert_req |=> state == S_BUSY && start && !done_flag && prm.x == $past(PWDATA[15:0]))
    else $error("input write did not start a conversion");

  a_params_frozen: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state == S_BUSY) |=> prm == $past(prm))
    else $error("parameters changed during a conversion");

  a_pv_pulse: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    PV_VALID |=> !PV_VALID)
    else $error("valid pulse longer than one cycle");

  a_pv_with_done: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    PV_VALID |-> done_flag && state == S_IDLE && result == PV_OUT)
    else $error("status not updated with the process value");

  a_divzero_result: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (PV_VALID && div_zero) |-> PV_OUT == '0)
    else $error("division by zero did not give zero");

endmodule

// file: zsc_exchange_model.sv
`timescale 1ns/10ps
module zsc_exchange_model
  import zsc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic [DW-1:0] pv,
  input  wire logic          pv_valid,
  output logic      [DW-1:0] latest,
  output logic      [15:0]   updates
);
  logic [DW-1:0] next_latest;
  logic [15:0]   next_updates;

  // controller side: copies each fresh value into its exchange word and counts the updates
  always_comb
  begin
    next_latest  = latest;
    next_updates = updates;
    if (pv_valid)
    begin
      next_latest  = pv;
      next_updates = updates + 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      latest  <= '0;
      updates <= '0;
    end
    else
    begin
      latest  <= next_latest;
      updates <= next_updates;
    end
  end
endmodule

// file: zsc_correction_test.sv
`timescale 1ns/10ps
`define CHECK_EQ(nm, ex, got) begin samples_checked++; if ((ex) !== (got)) begin num_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module zsc_correction_test
  import zsc_pkg::*;
;
  logic          core_clk = 0;
  logic          sys_rst  = 1;
  logic          psel     = 0;
  logic          penable  = 0;
  logic          pwrite   = 0;
  logic [AW-1:0] paddr    = '0;
  logic [DW-1:0] pwdata   = '0;
  logic [DW-1:0] prdata;
  logic          pready;
  logic          pslverr;
  logic [DW-1:0] pv_out;
  logic          pv_valid;
  logic [DW-1:0] latest;
  logic [15:0]   updates;
  logic [DW-1:0] rd;
  logic          er;
  int            num_errors = 0;
  int            samples_checked = 0;
  logic [AW-1:0] rst_addr [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                                    8'h20, 8'h24};
  logic [DW-1:0] rst_val  [10] = '{32'h0, 32'h0, 32'h0FA0, 32'h2710, 32'h0, 32'h01F4,
                                    32'h251C, 32'h0, 32'h0, 32'h0};

  always #50 core_clk = ~core_clk;

  zsc_correction zsc_correction_i (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PV_OUT(pv_out), .PV_VALID(pv_valid));
  zsc_exchange_model zsc_exchange_model_i (.clk(core_clk), .rst(sys_rst), .pv(pv_out),
    .pv_valid(pv_valid), .latest(latest), .updates(updates));

  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      num_errors++;
      give_verdict();
    end
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // exact rational evaluation, then half-away rounding; positions kept scaled by 1e4
  function automatic logic signed [DW-1:0] exp_pv(input logic [DW-1:0] c, a, s, e, d, zp,
                                                  sp, x);
    logic signed [127:0] la, ls, le, ld, lx, g, bn, cn, num, den;
    la = $signed(a[15:0]);
    ls = $signed(s[15:0]);
    ld = $signed(d[15:0]);
    lx = $signed(x[15:0]);
    le = e;
    g  = c[1] ? 128'sd10000000 : 128'sd10000;
    bn = la * 10000 + (ls - la) * zp[15:0];
    cn = la * 10000 + (ls - la) * sp[15:0];
    if (!c[0])
    begin
      num = (lx - la) * le + (la + ld) * g;
      den = g;
    end
    else
    begin
      if (cn == bn)
        return '0;
      num = (lx * 10000 - bn) * ((cn - la * 10000) * le - (bn - la * 10000) * g)
            + (ld * 10000 + bn) * g * (cn - bn);
      den = 10000 * g * (cn - bn);
    end
    if (den < 0)
    begin
      num = -num;
      den = -den;
    end
    if (num < 0)
      return -((-num * 2 + den) / (den * 2));
    return (num * 2 + den) / (den * 2);
  endfunction

  task automatic run(input logic [DW-1:0] c, a, s, e, d, zp, sp, x, input logic [DW-1:0] lit);
    logic [DW-1:0] ex;
    logic [15:0]   u0;
    int            n;
    ex = exp_pv(c, a, s, e, d, zp, sp, x);
    if (lit !== 32'hFFFF_FFFF)
      `CHECK_EQ("model", lit, ex)
    apb(1, ADDR_CTRL, c);
    apb(1, ADDR_ZERO_POINT, a);
    apb(1, ADDR_SPAN_POINT, s);
    apb(1, ADDR_SPAN_GAIN, e);
    apb(1, ADDR_ZERO_ADJ, d);
    apb(1, ADDR_ZERO_POS, zp);
    apb(1, ADDR_SPAN_POS, sp);
    u0 = updates;
    apb(1, ADDR_INPUT, x);
    `CHECK_EQ("input_err", 1'b0, er)
    for (n = 1; n < 300; n++)
    begin
      @(posedge core_clk);
      if (pv_valid === 1'b1)
        break;
    end
    if (n == 300)
    begin
      num_errors++;
      give_verdict();
    end
    `CHECK_EQ("latency", 132, n)
    `CHECK_EQ("pv_out", ex, pv_out)
    @(posedge core_clk);
    `CHECK_EQ("exchange", ex, latest)
    `CHECK_EQ("updates", u0 + 16'h0001, updates)
    apb(0, ADDR_RESULT, 0);
    `CHECK_EQ("result", ex, rd)
    apb(0, ADDR_STATUS, 0);
    `CHECK_EQ("status", (c[0] && zp == sp) ? 32'h6 : 32'h2, rd)
  endtask

  initial
  begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 10; i++)
    begin
      apb(0, rst_addr[i], 0);
      `CHECK_EQ("reset_value", rst_val[i], rd)
    end
    apb(1, ADDR_ZERO_ADJ, 32'hABCD_FFFD);
    apb(0, ADDR_ZERO_ADJ, 0);
    `CHECK_EQ("sign_ext", 32'hFFFF_FFFD, rd)
    apb(1, ADDR_ZERO_POS, 32'hABCD_01F4);
    apb(0, ADDR_ZERO_POS, 0);
    `CHECK_EQ("zero_ext", 32'h0000_01F4, rd)
    run(0, 0, 4000, 10060, 5, 500, 9500, 500, 508);
    run(1, 0, 4000, 10060, 5, 500, 9500, 500, 507);
    run(3, 0, 4000, 10060000, 5, 500, 9500, 500, 507);
    run(2, 0, 4000, 10060000, 5, 500, 9500, 500, 508);
    run(0, -200, 1800, 9995, -7, 500, 9500, -1234, -1240);
    run(0, 0, 4000, 15000, 0, 500, 9500, -3, -5);
    run(1, -500, 3000, 10123, 12, 1234, 8765, -777, 32'hFFFF_FFFF);
    run(1, 0, 4000, 10060, 0, 500, 9500, 200, 200);
    run(1, 0, 4000, 10060, 5, 5000, 5000, 500, 0);
    // busy window: parameters and a second input are refused until done
    apb(1, ADDR_INPUT, 100);
    apb(1, ADDR_ZERO_ADJ, 9);
    `CHECK_EQ("busy_param_err", 1'b1, er)
    apb(1, ADDR_INPUT, 200);
    `CHECK_EQ("busy_input_err", 1'b1, er)
    apb(0, ADDR_STATUS, 0);
    `CHECK_EQ("busy_status", 32'h5, rd)
    apb(0, ADDR_ZERO_ADJ, 0);
    `CHECK_EQ("adj_kept", 32'h5, rd)
    repeat (140) @(posedge core_clk);
    apb(0, ADDR_RESULT, 0);
    `CHECK_EQ("busy_result", exp_pv(1, 0, 4000, 10060, 5, 5000, 5000, 100), rd)
    apb(0, 8'h28, 0);
    `CHECK_EQ("unmapped_err", 1'b1, er)
    apb(1, ADDR_RESULT, 32'h1234);
    `CHECK_EQ("ro_err", 1'b1, er)
    // second reset with no conversion running must bring the span gain back to its reset value
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    apb(0, ADDR_SPAN_GAIN, 0);
    `CHECK_EQ("gain_after_reset", 32'h2710, rd)
    give_verdict();
  end
endmodule
